// ### shared/gpc_defines.vh
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

// ===========================================================
// bus geometry
`define GPC_DW            32
`define GPC_AW            8

// ===========================================================
// register byte offsets
`define GPC_OFS_OWN_TAKE  8'h00
`define GPC_OFS_OWN_GIVE  8'h04
`define GPC_OFS_OWN_STAT  8'h08
`define GPC_OFS_OE_SET    8'h10
`define GPC_OFS_OE_CLR    8'h14
`define GPC_OFS_OE_STAT   8'h18
`define GPC_OFS_OD_SET    8'h30
`define GPC_OFS_OD_CLR    8'h34
`define GPC_OFS_OD_STAT   8'h38
`define GPC_OFS_PIN_STAT  8'h3C
`define GPC_OFS_IRQ_SET   8'h40
`define GPC_OFS_IRQ_CLR   8'h44
`define GPC_OFS_IRQ_MASK  8'h48
`define GPC_OFS_CHG_STAT  8'h4C
`define GPC_OFS_CHG_CLR   8'h50

// ===========================================================
// reset values
`define GPC_RST_OWN       32'hFFFFFFFF
`define GPC_RST_ZERO      32'h00000000
`define GPC_ALL_ONES      32'hFFFFFFFF

// ===========================================================
// bus responses
`define GPC_RESP_OKAY     2'h0
`define GPC_RESP_SLVERR   2'h2

// ===========================================================
// write strobe lanes
`define GPC_NSTRB         4
`define GPC_BYTE_W        8

// ===========================================================
// pipeline fill before edges count
`define GPC_PRIME_W       3
`define GPC_PRIME_FULL    3'h7
`define GPC_PRIME_ZERO    3'h0

`endif

// ### rtl/gpc_top.v
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.vh"

module gpc_top
(
    // clock and reset
    input  wire                   clk_sys_i,
    input  wire                   rst_n_i,
    // axi4-lite write address
    input  wire [`GPC_AW-1:0]     s_axi_awaddr_i,
    input  wire [2:0]             s_axi_awprot_i,
    input  wire                   s_axi_awvalid_i,
    output wire                   s_axi_awready_o,
    // axi4-lite write data
    input  wire [`GPC_DW-1:0]     s_axi_wdata_i,
    input  wire [3:0]             s_axi_wstrb_i,
    input  wire                   s_axi_wvalid_i,
    output wire                   s_axi_wready_o,
    // axi4-lite write response
    output wire [1:0]             s_axi_bresp_o,
    output wire                   s_axi_bvalid_o,
    input  wire                   s_axi_bready_i,
    // axi4-lite read address
    input  wire [`GPC_AW-1:0]     s_axi_araddr_i,
    input  wire [2:0]             s_axi_arprot_i,
    input  wire                   s_axi_arvalid_i,
    output wire                   s_axi_arready_o,
    // axi4-lite read data
    output wire [`GPC_DW-1:0]     s_axi_rdata_o,
    output wire [1:0]             s_axi_rresp_o,
    output wire                   s_axi_rvalid_o,
    input  wire                   s_axi_rready_i,
    // pads
    input  wire [`GPC_DW-1:0]     pad_in_i,
    output wire [`GPC_DW-1:0]     pad_out_o,
    output wire [`GPC_DW-1:0]     pad_oe_n_o,
    // shared peripheral functions
    input  wire [`GPC_DW-1:0]     periph_out_i,
    input  wire [`GPC_DW-1:0]     periph_drive_i,
    output wire [`GPC_DW-1:0]     periph_in_o,
    // interrupt
    output wire                   irq_o
);

    // ===========================================================
    // reset release
    reg                     rst_meta_r;
    reg                     rst_sync_r;
    wire                    rst_n;

    // two-stage release of the async reset
    // assert is immediate, release waits two clocks
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    // ===========================================================
    // declarations
    reg  [`GPC_DW-1:0]      own_r;      // line owned by controller
    reg  [`GPC_DW-1:0]      oe_r;       // output driver enable
    reg  [`GPC_DW-1:0]      odata_r;    // stored output data
    reg  [`GPC_DW-1:0]      imr_r;      // interrupt enables
    reg  [`GPC_DW-1:0]      chg_r;      // change status
    reg  [`GPC_DW-1:0]      pin_meta_r;
    reg  [`GPC_DW-1:0]      pin_lvl_r;
    reg  [`GPC_DW-1:0]      pin_prev_r;
    reg  [`GPC_PRIME_W-1:0] prime_r;
    reg  [`GPC_DW-1:0]      pad_out_r;
    reg  [`GPC_DW-1:0]      pad_oe_n_r;
    reg  [`GPC_DW-1:0]      periph_in_r;
    reg                     irq_r;

    reg                     awready_r;
    reg                     wready_r;
    reg                     aw_full_r;
    reg                     w_full_r;
    reg  [`GPC_AW-1:0]      waddr_r;
    reg  [`GPC_DW-1:0]      wdata_r;
    reg  [3:0]              wstrb_r;
    reg                     bvalid_r;
    reg  [1:0]              bresp_r;
    reg                     arready_r;
    reg                     rvalid_r;
    reg  [1:0]              rresp_r;
    reg  [`GPC_DW-1:0]      rdata_r;

    wire                    aw_hs;
    wire                    w_hs;
    wire                    ar_hs;
    wire                    wr_go;
    wire [`GPC_DW-1:0]      wmask;
    wire [`GPC_DW-1:0]      wone;
    wire [`GPC_DW-1:0]      edges;
    wire                    rd_chg;
    reg                     wr_hit;
    reg                     rd_hit;
    reg  [`GPC_DW-1:0]      rd_mux;

    assign aw_hs = s_axi_awvalid_i & awready_r;
    assign w_hs  = s_axi_wvalid_i & wready_r;
    assign ar_hs = s_axi_arvalid_i & arready_r;
    assign wr_go = aw_full_r & w_full_r & ~bvalid_r;

    // ===========================================================
    // byte strobes widen to bit masks
    genvar gi;
    generate
        for (gi = 0; gi < `GPC_NSTRB; gi = gi + 1)
        begin : g_strb
            assign wmask[gi*`GPC_BYTE_W +: `GPC_BYTE_W] =
                {`GPC_BYTE_W{wstrb_r[gi]}};
        end
    endgenerate
    assign wone = wdata_r & wmask;

    // ===========================================================
    // write address decode
    always @*
    begin
        case (waddr_r)
            `GPC_OFS_OWN_TAKE, `GPC_OFS_OWN_GIVE,
            `GPC_OFS_OE_SET,   `GPC_OFS_OE_CLR,
            `GPC_OFS_OD_SET,   `GPC_OFS_OD_CLR,
            `GPC_OFS_IRQ_SET,  `GPC_OFS_IRQ_CLR,
            `GPC_OFS_CHG_CLR:  wr_hit = 1'b1;
            default:           wr_hit = 1'b0;
        endcase
    end

    // ===========================================================
    // axi write channel handling
    // readies stay low until the response is taken
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            waddr_r   <= {`GPC_AW{1'b0}};
            wdata_r   <= `GPC_RST_ZERO;
            wstrb_r   <= {`GPC_NSTRB{1'b0}};
            bvalid_r  <= 1'b0;
            bresp_r   <= `GPC_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                waddr_r   <= s_axi_awaddr_i;
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (w_hs)
            begin
                wdata_r  <= s_axi_wdata_i;
                wstrb_r  <= s_axi_wstrb_i;
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_go)
            begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready_i)
            begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // ===========================================================
    // register state updated by writes
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            own_r   <= `GPC_RST_OWN;
            oe_r    <= `GPC_RST_ZERO;
            odata_r <= `GPC_RST_ZERO;
            imr_r   <= `GPC_RST_ZERO;
        end
        else if (wr_go)
        begin
            case (waddr_r)
                `GPC_OFS_OWN_TAKE: own_r   <= own_r | wone;
                `GPC_OFS_OWN_GIVE: own_r   <= own_r & ~wone;
                `GPC_OFS_OE_SET:   oe_r    <= oe_r | wone;
                `GPC_OFS_OE_CLR:   oe_r    <= oe_r & ~wone;
                `GPC_OFS_OD_SET:   odata_r <= odata_r | wone;
                `GPC_OFS_OD_CLR:   odata_r <= odata_r & ~wone;
                `GPC_OFS_IRQ_SET:  imr_r   <= imr_r | wone;
                `GPC_OFS_IRQ_CLR:  imr_r   <= imr_r & ~wone;
                default:           imr_r   <= imr_r;
            endcase
        end
    end

    // ===========================================================
    // pad sampling and edge detect
    // pads are async: two flops before any reader
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= `GPC_RST_ZERO;
            pin_lvl_r  <= `GPC_RST_ZERO;
            pin_prev_r <= `GPC_RST_ZERO;
            prime_r    <= `GPC_PRIME_ZERO;
        end
        else
        begin
            pin_meta_r <= pad_in_i;
            pin_lvl_r  <= pin_meta_r;
            pin_prev_r <= pin_lvl_r;
            prime_r    <= {prime_r[`GPC_PRIME_W-2:0], 1'b1};
        end
    end
    // no edges until the sampling pipe holds real levels
    assign edges = (pin_lvl_r ^ pin_prev_r)
                 & {`GPC_DW{prime_r == `GPC_PRIME_FULL}};

    // ===========================================================
    // change status, set beats clear
    // an edge in the clear cycle is kept, none is lost
    assign rd_chg = ar_hs & (s_axi_araddr_i == `GPC_OFS_CHG_STAT);
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            chg_r <= `GPC_RST_ZERO;
        else if (rd_chg)
            chg_r <= edges;
        else if (wr_go && waddr_r == `GPC_OFS_CHG_CLR)
            chg_r <= (chg_r & ~wone) | edges;
        else
            chg_r <= chg_r | edges;
    end

    // ===========================================================
    // pads, peripheral input and interrupt
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_out_r   <= `GPC_RST_ZERO;
            pad_oe_n_r  <= `GPC_ALL_ONES;
            periph_in_r <= `GPC_RST_ZERO;
            irq_r       <= 1'b0;
        end
        else
        begin
            pad_out_r   <= (own_r & odata_r)
                         | (~own_r & periph_out_i);
            pad_oe_n_r  <= ~((own_r & oe_r)
                         | (~own_r & periph_drive_i));
            periph_in_r <= ~own_r & pin_lvl_r;
            irq_r       <= |(chg_r & imr_r);
        end
    end

    // ===========================================================
    // read decode
    always @*
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr_i)
            `GPC_OFS_OWN_STAT: rd_mux = own_r;
            `GPC_OFS_OE_STAT:  rd_mux = oe_r;
            `GPC_OFS_OD_STAT:  rd_mux = odata_r;
            `GPC_OFS_PIN_STAT: rd_mux = pin_lvl_r;
            `GPC_OFS_IRQ_MASK: rd_mux = imr_r;
            `GPC_OFS_CHG_STAT: rd_mux = chg_r;
            default:
            begin
                rd_mux = `GPC_RST_ZERO;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ===========================================================
    // axi read channel handling
    // data latched at the address edge: old status on read clear
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `GPC_RESP_OKAY;
            rdata_r   <= `GPC_RST_ZERO;
        end
        else if (ar_hs)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready_i)
        begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ===========================================================
    // outputs
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o  = wready_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign pad_out_o       = pad_out_r;
    assign pad_oe_n_o      = pad_oe_n_r;
    assign periph_in_o     = periph_in_r;
    assign irq_o           = irq_r;

endmodule // gpc_top

`default_nettype wire

// ### test/gpc_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// pad and outside world
module gpc_pad_model
(
    input  wire logic [31:0] pad_out_i,
    input  wire logic [31:0] pad_oe_n_i,
    input  wire logic [31:0] ext_lvl_i,
    output wire logic [31:0] pad_lvl_o
);
    // a driven pad follows the block, a released one the outside driver
    assign pad_lvl_o = (pad_out_i & ~pad_oe_n_i) | (ext_lvl_i & pad_oe_n_i);
endmodule // gpc_pad_model

`default_nettype wire

// ### test/gpc_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// register bus checker
module gpc_chk
(
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  s_axi_awaddr_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [7:0]  s_axi_araddr_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // both write halves taken at one edge
    sequence s_wr_both;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    // read address taken
    sequence s_rd_take;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence

    a_wr_resp_lat: assert property (s_wr_both |-> ##2 s_axi_bvalid_o)
        else $error("write response not two cycles after address");
    a_rd_resp_lat: assert property (s_rd_take |=> s_axi_rvalid_o)
        else $error("read data not one cycle after address");
    a_aw_busy_drop: assert property (s_wr_both |=> !s_axi_awready_o)
        else $error("write address ready stayed high");
    a_ar_busy_hold: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address ready during read data");
    a_rd_data_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
        else $error("read data changed before taken");
    a_wr_hole_err: assert property ((s_wr_both and s_axi_awaddr_i == 8'h0C)
        |-> ##2 (s_axi_bvalid_o && s_axi_bresp_o == 2'h2))
        else $error("unmapped write not refused");
    a_rd_wo_err: assert property ((s_rd_take and s_axi_araddr_i == 8'h30)
        |=> (s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h00000000))
        else $error("write only read not refused");
    a_wr_reopen: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
        s_axi_awready_o && s_axi_wready_o)
        else $error("write channel not reopened");
endmodule // gpc_chk

bind gpc_top gpc_chk i_chk (.*);

`default_nettype wire

// ### test/tb_pio_output_data_and_pin_change_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defines.vh"

// ==========================================================
// bench top
module tb_pio_output_data_and_pin_change_irq;
    logic clk_sys_i, rst_n_i, irq_o;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic s_axi_rvalid_o, s_axi_rready_i;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [2:0] s_axi_awprot_i, s_axi_arprot_i;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, pad_in_i, pad_out_o;
    logic [31:0] pad_oe_n_o, periph_out_i, periph_drive_i, periph_in_o;
    logic [31:0] ext_lvl, rv, a, b, m, g, e, od;
    integer n_mismatch, num_checks, seed, i;

    gpc_top i_dut (.*);
    gpc_pad_model i_pad (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
                         .ext_lvl_i(ext_lvl), .pad_lvl_o(pad_in_i));

    // ======================================================
    // helpers
    function [31:0] lvl_f;
        input [31:0] mo;
        input [31:0] gv;
        reg   [31:0] drv;
        begin
            drv = (mo & ~gv) | (periph_drive_i & gv);
            lvl_f = (((od & ~gv) | (periph_out_i & gv)) & drv) | (ext_lvl & ~drv);
        end
    endfunction

    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task wr(input [7:0] ad, input [31:0] d);
        begin
            @(posedge clk_sys_i);
            s_axi_awaddr_i <= ad;
            s_axi_wdata_i <= d;
            s_axi_awvalid_i <= 1'b1;
            s_axi_wvalid_i <= 1'b1;
            s_axi_bready_i <= 1'b1;
            do
            begin
                @(posedge clk_sys_i);
                if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
                if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            end
            while (s_axi_bvalid_o !== 1'b1);
            rs = s_axi_bresp_o;
            s_axi_bready_i <= 1'b0;
        end
    endtask

    task rd(input [7:0] ad);
        begin
            @(posedge clk_sys_i);
            s_axi_araddr_i <= ad;
            s_axi_arvalid_i <= 1'b1;
            do @(posedge clk_sys_i); while (s_axi_arready_o !== 1'b1);
            s_axi_arvalid_i <= 1'b0;
            repeat ($unsigned($random(seed)) % 3) @(posedge clk_sys_i);
            s_axi_rready_i <= 1'b1;
            do @(posedge clk_sys_i); while (s_axi_rvalid_o !== 1'b1);
            rv = s_axi_rdata_o;
            rs = s_axi_rresp_o;
            s_axi_rready_i <= 1'b0;
        end
    endtask

    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // ======================================================
    // clock and watchdog
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        #100000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end

    // ======================================================
    // main sequence
    initial
    begin
        seed = 19; n_mismatch = 0; num_checks = 0; rst_n_i = 1'b0;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
        {s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
        s_axi_awaddr_i = 8'h00; s_axi_araddr_i = 8'h00;
        s_axi_awprot_i = 3'h0; s_axi_arprot_i = 3'h0; s_axi_wstrb_i = 4'hF;
        s_axi_wdata_i = 32'h0; periph_out_i = 32'h0; periph_drive_i = 32'h0;
        ext_lvl = $random(seed); od = 32'h0;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rd(8'h38); chk(rv, 32'h0);
        rd(8'h48); chk(rv, 32'h0);
        rd(8'h4C); chk(rv, 32'h0);
        chk(pad_oe_n_o, 32'hFFFFFFFF);
        chk(periph_in_o, 32'h0);
        for (i = 0; i < 4; i = i + 1)
        begin
            a = ext_lvl; b = $random(seed); ext_lvl <= b;
            repeat (4) @(posedge clk_sys_i);
            rd(8'h3C); chk(rv, b);
            rd(8'h4C); chk(rv, a ^ b);
            rd(8'h4C); chk(rv, 32'h0);
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            a = $random(seed); b = $random(seed);
            wr(8'h30, a); od = od | a; rd(8'h38); chk(rv, od);
            wr(8'h34, b); od = od & ~b; rd(8'h38); chk(rv, od);
        end
        wr(8'h38, 32'hFFFFFFFF); chk(rs, `GPC_RESP_SLVERR);
        rd(8'h38); chk(rv, od);
        wr(8'h0C, 32'h0); chk(rs, `GPC_RESP_SLVERR);
        rd(8'h0C); chk(rs, `GPC_RESP_SLVERR);
        rd(8'h30); chk(rs, `GPC_RESP_SLVERR); chk(rv, 32'h0);
        // output enables, then hand some lines to the peripherals
        periph_out_i <= $random(seed); periph_drive_i <= $random(seed);
        m = $random(seed); g = $random(seed);
        wr(8'h10, m); rd(8'h18); chk(rv, m);
        repeat (2) @(posedge clk_sys_i);
        chk(pad_oe_n_o, ~m);
        chk(pad_out_o & m, od & m);
        wr(8'h04, g); repeat (4) @(posedge clk_sys_i);
        chk(pad_oe_n_o, (~m & ~g) | (~periph_drive_i & g));
        chk(pad_out_o & g, periph_out_i & g);
        chk(periph_in_o, lvl_f(m, g) & g);
        rd(8'h3C); chk(rv, lvl_f(m, g));
        rd(8'h08); chk(rv, ~g);
        wr(8'h14, 32'hFFFFFFFF); rd(8'h18); chk(rv, 32'h0);
        wr(8'h00, 32'hFFFFFFFF); repeat (4) @(posedge clk_sys_i);
        rd(8'h4C);
        // change interrupt enable, disable and read clear
        e = $random(seed) | 32'h1;
        wr(8'h40, e); rd(8'h48); chk(rv, e);
        chk(irq_o, 32'h0);
        ext_lvl <= ext_lvl ^ 32'h1; repeat (5) @(posedge clk_sys_i);
        chk(irq_o, 32'h1);
        rd(8'h4C); chk(rv, 32'h1);
        repeat (2) @(posedge clk_sys_i);
        chk(irq_o, 32'h0);
        wr(8'h44, 32'h1); rd(8'h48); chk(rv, e & ~32'h1);
        ext_lvl <= ext_lvl ^ 32'h1; repeat (5) @(posedge clk_sys_i);
        chk(irq_o, 32'h0);
        rd(8'h4C); chk(rv, 32'h1);
        // write-one clear of the change status
        ext_lvl <= ext_lvl ^ 32'h1; repeat (5) @(posedge clk_sys_i);
        wr(8'h50, 32'h1); rd(8'h4C); chk(rv, 32'h0);
        // reset in mid-run; the refilled pipe must not fake an edge
        rst_n_i <= 1'b0; repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1; repeat (3) @(posedge clk_sys_i);
        rd(8'h38); chk(rv, 32'h0);
        rd(8'h48); chk(rv, 32'h0);
        rd(8'h08); chk(rv, `GPC_RST_OWN);
        rd(8'h4C); chk(rv, 32'h0);
        give_verdict;
    end
endmodule // tb_pio_output_data_and_pin_change_irq

`default_nettype wire
